// *** shared/spp_pkg.sv ***
// Shared constants for the serial peripheral port: register map,
// bit positions, reset values and master clock rate reloads.
// Assumes a byte-wide register port with a 2-bit word address.
package spp_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W   = 2;
   localparam logic [1:0]  ADR_CTRL = 2'h0;  // port_control_register
   localparam logic [1:0]  ADR_STAT = 2'h1;  // port_status_register
   localparam logic [1:0]  ADR_DATA = 2'h2;  // shift_data_register

   // Control register fields
   localparam int CB_IRQE    = 7;  // transfer_irq_enable
   localparam int CB_SPE     = 6;  // serial_port_enable
   localparam int CB_MASTER_SELECT    = 4;  // master_select
   localparam int CB_CLOCK_IDLE_LEVEL    = 3;  // clock_idle_level
   localparam int CB_CAPTURE_EDGE_PHASE    = 2;  // capture_edge_phase
   localparam int CB_RATE_HI = 1;  // master_rate_select_hi
   localparam int CB_RATE_LO = 0;  // master_rate_select_lo

   // Status register fields
   localparam int SB_DONE = 7;     // transfer_done_flag
   localparam int SB_WRITE_COLLISION_FLAG = 6;     // write_collision_flag
   localparam int SB_MODE_FAULT_FLAG = 4;     // mode_fault_flag

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] RD_ZERO  = 8'h00;

   // ----------------------------------------------------------------
   // Transfer timing
   // ----------------------------------------------------------------
   localparam logic [3:0] LAST_CAP  = 4'h7;   // index of the 8th capture
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [4:0] LAST_EDGE = 5'hf;   // 16 edges, counted from 0

   // Half period of SCK in CPU clocks, minus one, per rate select
   localparam logic [5:0] RATE0_RELOAD = 6'h03;  // CPU clock / 8
   localparam logic [5:0] RATE1_RELOAD = 6'h07;  // CPU clock / 16
   localparam logic [5:0] RATE2_RELOAD = 6'h0f;  // CPU clock / 32
   localparam logic [5:0] RATE3_RELOAD = 6'h1f;  // CPU clock / 64

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } spp_state_t;

   // Divider reload for a rate select code
   function automatic logic [5:0] spp_reload(input logic [1:0] sel);
      logic [5:0] r;
      r = RATE0_RELOAD;
      case (sel)
         2'h0:    r = RATE0_RELOAD;
         2'h1:    r = RATE1_RELOAD;
         2'h2:    r = RATE2_RELOAD;
         default: r = RATE3_RELOAD;
      endcase
      return r;
   endfunction

endpackage

// *** rtl/spp_core.sv ***
// Full-duplex serial peripheral port, master or slave, byte-wide.
// Assumes a CPU register port on CLK and SPI pins from outside the
// clock domain; pin inputs are synchronised before use.
`timescale 1ns/100ps

module spp_core (
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   input  wire logic [1:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       GLOBAL_IRQ_MASK,
   output logic            IRQ,
   input  wire logic       SS_N,
   input  wire logic       SCK_I,
   output logic            SCK_O,
   output logic            SCK_OE,
   input  wire logic       MOSI_I,
   output logic            MOSI_O,
   output logic            MOSI_OE,
   input  wire logic       MISO_I,
   output logic            MISO_O,
   output logic            MISO_OE
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0]        ss_sy;
   logic [2:0]        sck_sy;
   logic [1:0]        mosi_sy;
   logic [1:0]        miso_sy;
   logic              irqe;
   logic              serial_port_enable;
   logic              master_select;
   logic              clock_idle_level;
   logic              capture_edge_phase;
   logic [1:0]        rate;
   logic              done;
   logic              done_arm;
   logic              write_collision_flag;
   logic              write_collision_flag_arm;
   logic              mode_fault_flag;
   logic              mode_fault_flag_arm;
   spp_pkg::spp_state_t state;
   logic [7:0]        sreg;
   logic [7:0]        rx_buf;
   logic              out_bit;
   logic [3:0]        bit_cnt;
   logic [5:0]        div_cnt;
   logic              sck_q;
   logic              slv_act;

   logic ss_low, sck_s, sck_p, rx_bit;
   logic cr_wr, st_acc, dr_wr, dr_rd;
   logic mode_fault_flag_evt, running, busy, wr_ok, start;
   logic m_edge, m_lead, s_sel, s_edge, s_lead;
   logic edge_any, lead, cap, launch, byte_end;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two stages on every pin, three on SCK; stages 2 and 3 of SCK feed the edge detector
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ss_sy   <= '1;
         sck_sy  <= '0;
         mosi_sy <= '0;
         miso_sy <= '0;
      end else begin
         ss_sy   <= {ss_sy[0], SS_N};
         sck_sy  <= {sck_sy[1:0], SCK_I};
         mosi_sy <= {mosi_sy[0], MOSI_I};
         miso_sy <= {miso_sy[0], MISO_I};
      end
   end

   assign ss_low = !ss_sy[1];
   assign sck_s  = sck_sy[1];
   assign sck_p  = sck_sy[2];
   assign rx_bit = master_select ? miso_sy[1] : mosi_sy[1];

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   assign cr_wr  = WR && (ADDR == spp_pkg::ADR_CTRL);
   assign st_acc = (WR || RD) && (ADDR == spp_pkg::ADR_STAT);
   assign dr_wr  = WR && (ADDR == spp_pkg::ADR_DATA);
   assign dr_rd  = RD && (ADDR == spp_pkg::ADR_DATA);

   // ----------------------------------------------------------------
   // Transfer sequencing
   // ----------------------------------------------------------------
   // SS low seen while mastering is a bus fight with another master
   assign mode_fault_flag_evt = serial_port_enable && master_select && ss_low;
   assign running  = (state == spp_pkg::ST_RUN);
   // Phase set: slave is busy only once the first edge arrived
   assign busy = master_select ? running
                      : (ss_low && (!capture_edge_phase || slv_act));
   // Writes are held off while the done flag waits for a status read
   assign wr_ok = dr_wr && !busy && !(done && !done_arm);
   assign start = wr_ok && master_select && serial_port_enable && !mode_fault_flag_evt;

   assign m_edge = master_select && running && (div_cnt == '0);
   assign m_lead = m_edge && (sck_q == clock_idle_level);
   assign s_sel  = !master_select && serial_port_enable && ss_low;
   assign s_edge = s_sel && (sck_s != sck_p);
   assign s_lead = s_edge && (sck_p == clock_idle_level);
   assign edge_any = m_edge || s_edge;
   assign lead     = m_lead || s_lead;
   // Phase clear captures on the leading edge, set on the trailing
   assign cap    = edge_any && (lead ^ capture_edge_phase);
   assign launch = edge_any && !(lead ^ capture_edge_phase);
   // Phase clear ends on the 16th edge so SCK is back at rest
   assign byte_end = capture_edge_phase ? (cap && bit_cnt == spp_pkg::LAST_CAP)
                          : (launch && bit_cnt == spp_pkg::BYTE_BITS);

   // Master state: run from the starting write until the last edge
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= spp_pkg::ST_IDLE;
      end else begin
         case (state)
            spp_pkg::ST_IDLE: begin
               if (start)
                  state <= spp_pkg::ST_RUN;
            end
            spp_pkg::ST_RUN: begin
               if (byte_end || mode_fault_flag_evt || !master_select)
                  state <= spp_pkg::ST_IDLE;
            end
            default: state <= spp_pkg::ST_IDLE;
         endcase
      end
   end

   // Slave activity: first edge while selected begins the byte
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         slv_act <= 1'b0;
      end else if (!s_sel || byte_end) begin
         slv_act <= 1'b0;
      end else if (s_edge) begin
         slv_act <= 1'b1;
      end
   end

   // SCK divider and master clock level
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_cnt <= '0;
         sck_q   <= 1'b0;
      end else if (start) begin
         div_cnt <= spp_pkg::spp_reload(rate);
         sck_q   <= clock_idle_level;
      end else if (running && !byte_end) begin
         div_cnt <= (div_cnt == '0) ? spp_pkg::spp_reload(rate)
                                    : div_cnt - 6'h01;
         if (m_edge)
            sck_q <= !sck_q;
      end else begin
         div_cnt <= '0;
         sck_q   <= clock_idle_level;
      end
   end

   // Bit counter: one step per capture, cleared between bytes
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bit_cnt <= '0;
      end else if (start || byte_end || (!master_select && !s_sel)) begin
         bit_cnt <= '0;
      end else if (cap) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Shift register and outgoing bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sreg    <= spp_pkg::DATA_RST;
         out_bit <= 1'b0;
      end else if (wr_ok) begin
         sreg    <= WDATA;
         out_bit <= WDATA[7];  // Phase clear needs MSB before edge 1
      end else begin
         if (cap)
            sreg <= {sreg[6:0], rx_bit};
         if (launch)
            out_bit <= cap ? sreg[6] : sreg[7];
      end
   end

   // Receive buffer, loaded in the cycle that ends the byte
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_buf <= spp_pkg::DATA_RST;
      end else if (byte_end) begin
         rx_buf <= capture_edge_phase ? {sreg[6:0], rx_bit} : sreg;
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Fault beats a same-cycle write; enable and master cannot be set
   // while the fault is pending and not yet acknowledged by a status
   // access
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         {irqe, serial_port_enable, master_select, clock_idle_level, capture_edge_phase} <= '0;
         rate <= '0;
      end else if (mode_fault_flag_evt) begin
         serial_port_enable  <= 1'b0;
         master_select <= 1'b0;
      end else if (cr_wr) begin
         irqe <= WDATA[spp_pkg::CB_IRQE];
         serial_port_enable  <= WDATA[spp_pkg::CB_SPE] && !(mode_fault_flag && !mode_fault_flag_arm);
         master_select <= WDATA[spp_pkg::CB_MASTER_SELECT] && !(mode_fault_flag && !mode_fault_flag_arm);
         clock_idle_level <= WDATA[spp_pkg::CB_CLOCK_IDLE_LEVEL];
         capture_edge_phase <= WDATA[spp_pkg::CB_CAPTURE_EDGE_PHASE];
         rate <= {WDATA[spp_pkg::CB_RATE_HI], WDATA[spp_pkg::CB_RATE_LO]};
      end
   end

   // ----------------------------------------------------------------
   // Status flags and their clearing sequences
   // ----------------------------------------------------------------
   // Done flag; a set in the clearing cycle wins
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         done     <= 1'b0;
         done_arm <= 1'b0;
      end else if (byte_end) begin
         done     <= 1'b1;
         done_arm <= 1'b0;
      end else begin
         if (dr_rd && done_arm) begin
            done     <= 1'b0;
            done_arm <= 1'b0;
         end else if (st_acc && done) begin
            done_arm <= 1'b1;
         end
      end
   end

   // Collision flag: status access then any data access clears it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         write_collision_flag     <= 1'b0;
         write_collision_flag_arm <= 1'b0;
      end else if (dr_wr && busy) begin
         write_collision_flag     <= 1'b1;
         write_collision_flag_arm <= 1'b0;
      end else if ((dr_rd || dr_wr) && write_collision_flag_arm) begin
         write_collision_flag     <= 1'b0;
         write_collision_flag_arm <= 1'b0;
      end else if (st_acc && write_collision_flag) begin
         write_collision_flag_arm <= 1'b1;
      end
   end

   // Mode fault: status access then control write clears it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode_fault_flag     <= 1'b0;
         mode_fault_flag_arm <= 1'b0;
      end else if (mode_fault_flag_evt) begin
         mode_fault_flag     <= 1'b1;
         mode_fault_flag_arm <= 1'b0;
      end else if (cr_wr && mode_fault_flag_arm) begin
         mode_fault_flag     <= 1'b0;
         mode_fault_flag_arm <= 1'b0;
      end else if (st_acc && mode_fault_flag) begin
         mode_fault_flag_arm <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Read data, interrupt and pin drivers
   // ----------------------------------------------------------------
   // Read data valid only in the cycle after the strobe
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RDATA <= spp_pkg::RD_ZERO;
      end else if (RD) begin
         case (ADDR)
            spp_pkg::ADR_CTRL: begin
               RDATA <= spp_pkg::RD_ZERO;
               RDATA[spp_pkg::CB_IRQE]    <= irqe;
               RDATA[spp_pkg::CB_SPE]     <= serial_port_enable;
               RDATA[spp_pkg::CB_MASTER_SELECT]    <= master_select;
               RDATA[spp_pkg::CB_CLOCK_IDLE_LEVEL]    <= clock_idle_level;
               RDATA[spp_pkg::CB_CAPTURE_EDGE_PHASE]    <= capture_edge_phase;
               RDATA[spp_pkg::CB_RATE_HI] <= rate[1];
               RDATA[spp_pkg::CB_RATE_LO] <= rate[0];
            end
            spp_pkg::ADR_STAT: begin
               RDATA <= spp_pkg::RD_ZERO;
               RDATA[spp_pkg::SB_DONE] <= done;
               RDATA[spp_pkg::SB_WRITE_COLLISION_FLAG] <= write_collision_flag;
               RDATA[spp_pkg::SB_MODE_FAULT_FLAG] <= mode_fault_flag;
            end
            spp_pkg::ADR_DATA: RDATA <= rx_buf;
            default:           RDATA <= spp_pkg::RD_ZERO;
         endcase
      end else begin
         RDATA <= spp_pkg::RD_ZERO;
      end
   end

   // Collision never raises the request, only done and fault do
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= irqe && !GLOBAL_IRQ_MASK && (done || mode_fault_flag);
      end
   end

   // Enables lag the mode bits by one clock so every pin is a flop
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SCK_OE  <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_OE <= 1'b0;
      end else begin
         SCK_OE  <= serial_port_enable && master_select && !mode_fault_flag_evt;
         MOSI_OE <= serial_port_enable && master_select && !mode_fault_flag_evt;
         MISO_OE <= s_sel;
      end
   end

   assign SCK_O  = sck_q;
   assign MOSI_O = out_bit;
   assign MISO_O = out_bit;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [4:0] hlp_edges;

   // Edges seen since the master started the byte
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         hlp_edges <= '0;
      else if (start)
         hlp_edges <= '0;
      else if (m_edge)
         hlp_edges <= hlp_edges + 5'h01;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   chk_done_set:     assert property (byte_end |=> done)
      else $error("done flag not set after byte end");
   chk_buf_copy:     assert property (byte_end && !capture_edge_phase |=>
      rx_buf == $past(sreg))
      else $error("receive buffer not loaded");
   chk_clear_seq:    assert property (
      done && !done_arm && dr_rd && !byte_end |=> done)
      else $error("done flag cleared without status access");
   chk_wr_inhibit:   assert property (
      done && !done_arm && dr_wr && !cap |=> sreg == $past(sreg))
      else $error("data write taken while done pending");
   chk_write_collision_flag_set:     assert property (dr_wr && busy |=> write_collision_flag)
      else $error("collision not flagged");
   chk_mode_fault_flag_drop:    assert property (mode_fault_flag_evt |=>
      mode_fault_flag && !serial_port_enable && !master_select ##1 !SCK_OE)
      else $error("mode fault did not drop master");
   chk_sixteen_edges: assert property (
      master_select && running && byte_end |-> hlp_edges == spp_pkg::LAST_EDGE)
      else $error("byte did not take sixteen edges");
   chk_sck_rest:     assert property (
      !running && !$past(running) |-> SCK_O == $past(clock_idle_level))
      else $error("SCK not at idle level");
   chk_miso_release: assert property (!ss_low |=> !MISO_OE)
      else $error("MISO driven while deselected");
   chk_irq_gate:     assert property (GLOBAL_IRQ_MASK |=> !IRQ)
      else $error("interrupt raised while CPU mask set");
   chk_master_start: assert property (start |=>
      running && sreg == $past(WDATA))
      else $error("master write did not start transfer");

   cov_master_byte:  cover property (master_select && byte_end);
   cov_slave_byte:   cover property (!master_select && byte_end);
   cov_mode_fault:   cover property (mode_fault_flag_evt);
   cov_collision:    cover property (dr_wr && busy);

endmodule

// *** verif/spp_peer.sv ***
// Far-side peripheral model for the port in master mode.
// Assumes the bench resolves SCK and MOSI and raises sel per byte.
`timescale 1ns/100ps

module spp_peer (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel,
   input  wire logic       clock_idle_level,
   input  wire logic       capture_edge_phase,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   // ----------------------------------------------------------------
   // Shifting
   // ----------------------------------------------------------------
   logic [7:0] sh;
   logic       bit_out = 1'b0;
   logic       lead_q  = 1'b0;
   wire        lead    = sck ^ clock_idle_level;

   // One process owns all state; a clock edge is told apart from a
   // select by comparing the clock with its last seen level
   always @(sel or lead) begin
      if (lead !== lead_q) begin
         lead_q = lead;
         // Capture on the leading edge with phase clear, else trailing
         if (sel && (lead ^ capture_edge_phase)) begin
            rx_byte = {rx_byte[6:0], mosi};
         end else if (sel && capture_edge_phase) begin
            bit_out = sh[7];
            sh = sh << 1;
         end else if (sel) begin
            sh = sh << 1;
            bit_out = sh[7];
         end
      end else if (sel) begin
         // Load on select so the MSB waits before the first edge
         sh = tx_byte;
         bit_out = tx_byte[7];
      end
   end

   // Released line flips so a stale bit cannot pass for data
   assign miso = sel ? bit_out : ~bit_out;
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the serial peripheral port core.
// Assumes spp_pkg, spp_core and spp_peer are compiled before it.
`timescale 1ns/100ps

module testbench;
   // ----------------------------------------------------------------
   // Signals and wiring
   // ----------------------------------------------------------------
   logic       clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic       mask = 1'b1, ss_n = 1'b1, sck_drv = 1'b0, mosi_drv = 1'b0;
   logic       sel = 1'b0, irq, sck_o, sck_oe, mosi_o, mosi_oe;
   logic       miso_o, miso_oe, peer_miso;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, ctl = 8'h00, peer_tx = 8'h00, peer_rx;
   int         num_errors = 0, n_tests = 0, edges = 0, t1 = 0, t2 = 0;
   // Each line takes the level of whoever enables its driver
   wire        sck_w  = sck_oe ? sck_o : sck_drv;
   wire        mosi_w = mosi_oe ? mosi_o : mosi_drv;
   wire        miso_w = miso_oe ? miso_o : peer_miso;

   // Clock, 10 ns period
   always #5 clk = ~clk;

   spp_core i_dut (
      .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .GLOBAL_IRQ_MASK(mask), .IRQ(irq),
      .SS_N(ss_n), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
      .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
      .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe)
   );
   spp_peer i_peer (
      .sck(sck_w), .mosi(mosi_w), .sel(sel), .clock_idle_level(ctl[3]), .capture_edge_phase(ctl[2]),
      .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx)
   );

   // Count SCK edges; the first two give the half period
   always @(sck_o) begin
      edges++;
      if (edges == 1) t1 = int'($time);
      if (edges == 2) t2 = int'($time);
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string s, input logic [7:0] e,
                        input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   // One strobe cycle, then a gap so strobes never get two assignments
   task automatic bus(input logic w, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 q = rdata;
      @(posedge clk);
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [1:0] a, input logic [7:0] e,
                         input string s);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check(s, e, q);
   endtask

   // Waits a bounded time for n SCK edges
   task automatic wait_edges(input int n);
      int k;
      k = 0;
      while (edges < n && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (k == 3000) begin
         num_errors++;
         $display("Error sck edges expected %0d seen %0d", n, edges);
         end_sim();
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic start(input logic [7:0] c, input logic [7:0] tx,
                        input logic [7:0] ptx);
      ctl = c;
      peer_tx = ptx;
      wr_reg(spp_pkg::ADR_CTRL, c);
      repeat (2) @(posedge clk);
      check("sck idle", {7'h0, c[3]}, {7'h0, sck_o});
      edges = 0;
      sel = 1'b1;
      wr_reg(spp_pkg::ADR_DATA, tx);
   endtask

   task automatic xfer(input logic [7:0] c, input logic [7:0] tx,
                       input logic [7:0] ptx);
      start(c, tx, ptx);
      wait_edges(16);
      sel = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check("pins", 8'h00, {4'h0, irq, sck_oe, mosi_oe, miso_oe});
      for (int a = 0; a < 4; a++) begin
         rd_chk(2'(a), 8'h00, "reset value");
      end
      $display("test reset done");
   endtask

   // Each pass pairs one clock mode with one rate code
   task automatic t_modes();
      logic [5:0] rl [4];
      rl = '{spp_pkg::RATE0_RELOAD, spp_pkg::RATE1_RELOAD,
             spp_pkg::RATE2_RELOAD, spp_pkg::RATE3_RELOAD};
      for (int m = 0; m < 4; m++) begin
         xfer(8'h50 | 8'(m * 5), 8'ha5 ^ 8'(m), 8'h3c + 8'(m));
         check("sck rest", {7'h0, ctl[3]}, {7'h0, sck_o});
         check("sck edges", 8'h10, 8'(edges));
         check("half", {2'h0, rl[m]} + 8'h01, 8'((t2 - t1) / 10));
         check("peer rx", 8'ha5 ^ 8'(m), peer_rx);
         rd_chk(spp_pkg::ADR_STAT, 8'h80, "done");
         rd_chk(spp_pkg::ADR_DATA, 8'h3c + 8'(m), "rx buffer");
         rd_chk(spp_pkg::ADR_STAT, 8'h00, "done clear");
      end
      $display("test modes done");
   endtask

   task automatic t_flags();
      logic [7:0] q;
      xfer(8'hd0, 8'h96, 8'h69);
      check("irq masked", 8'h00, {7'h0, irq});
      mask <= 1'b0;
      repeat (2) @(posedge clk);
      check("irq", 8'h01, {7'h0, irq});
      edges = 0;
      wr_reg(spp_pkg::ADR_DATA, 8'h11);
      repeat (40) @(posedge clk);
      check("ignored write", 8'h00, 8'(edges));
      rd_chk(spp_pkg::ADR_DATA, 8'h69, "early read");
      bus(1'b0, spp_pkg::ADR_STAT, 8'h00, q);
      check("done kept", 8'h80, q & 8'h80);
      rd_chk(spp_pkg::ADR_DATA, 8'h69, "rx buffer");
      rd_chk(spp_pkg::ADR_STAT, 8'h00, "flags clear");
      check("irq low", 8'h00, {7'h0, irq});
      $display("test flags done");
   endtask

   task automatic t_collide();
      start(8'hd0, 8'hc3, 8'h5a);
      wait_edges(4);
      wr_reg(spp_pkg::ADR_DATA, 8'h00);
      check("irq on collision", 8'h00, {7'h0, irq});
      wait_edges(16);
      sel = 1'b0;
      check("peer rx", 8'hc3, peer_rx);
      rd_chk(spp_pkg::ADR_STAT, 8'hc0, "collision");
      rd_chk(spp_pkg::ADR_DATA, 8'h5a, "rx buffer");
      rd_chk(spp_pkg::ADR_STAT, 8'h00, "flags clear");
      $display("test collide done");
   endtask

   task automatic t_fault();
      wr_reg(spp_pkg::ADR_CTRL, 8'h50);
      // The pin enable lags the mode bits by one clock
      @(posedge clk);
      check("sck driven", 8'h01, {7'h0, sck_oe});
      ss_n <= 1'b0;
      repeat (6) @(posedge clk);
      check("sck dropped", 8'h00, {7'h0, sck_oe});
      ss_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(spp_pkg::ADR_STAT, 8'h10, "mode fault");
      rd_chk(spp_pkg::ADR_CTRL, 8'h00, "ctrl after fault");
      wr_reg(spp_pkg::ADR_CTRL, 8'h00);
      rd_chk(spp_pkg::ADR_STAT, 8'h00, "fault clear");
      $display("test fault done");
   endtask

   // Bench plays the remote master, slowest rate code set and unused;
   // ph picks the capture phase of both ends
   task automatic t_slave(input logic ph);
      logic [7:0] got;
      logic [7:0] tx;
      logic [7:0] ld;
      tx = ph ? 8'h3e : 8'ha7;
      ld = ph ? 8'hc4 : 8'h5b;
      wr_reg(spp_pkg::ADR_CTRL, 8'h43 | {5'h0, ph, 2'h0});
      wr_reg(spp_pkg::ADR_DATA, ld);
      check("miso released", 8'h00, {7'h0, miso_oe});
      ss_n <= 1'b0;
      repeat (6) @(posedge clk);
      check("miso driven", 8'h01, {7'h0, miso_oe});
      for (int i = 7; i >= 0; i--) begin
         // Phase set: the remote launches on the leading edge
         if (ph)
            sck_drv <= 1'b1;
         mosi_drv <= tx[i];
         repeat (8) @(posedge clk);
         got[i] = miso_w;
         sck_drv <= !ph;
         repeat (8) @(posedge clk);
         if (!ph)
            sck_drv <= 1'b0;
      end
      repeat (8) @(posedge clk);
      check("slave tx", ld, got);
      rd_chk(spp_pkg::ADR_STAT, 8'h80, "slave done");
      rd_chk(spp_pkg::ADR_DATA, tx, "slave rx");
      ss_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("miso release", 8'h00, {7'h0, miso_oe});
      $display("test slave done");
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_modes();
      t_flags();
      t_collide();
      t_fault();
      t_slave(1'b0);
      t_slave(1'b1);
      end_sim();
   end
endmodule
